// ===== rtl/lvr_cnt_if.sv
`timescale 1ns/1ns
interface lvr_cnt_if;
  logic run;
  logic done;
  modport ctl (output run, input done);
  modport cnt (input run, output done);
endinterface

// ===== rtl/lvr_defines.svh
`ifndef LVR_DEFINES_SVH
`define LVR_DEFINES_SVH

// Register byte addresses
`define LVR_ADR_VSEL 8'h00
`define LVR_ADR_CAUSE 8'h04
`define LVR_ADR_STAT 8'h08
`define LVR_ADR_WDEN 8'h0c
`define LVR_ADR_IRQ_ST 8'h10
`define LVR_ADR_IRQ_MSK 8'h14

// Voltage select codes
`define LVR_VSEL_POR 8'h66
`define LVR_VSEL_1V9 8'h55
`define LVR_VSEL_2V55 8'h33
`define LVR_VSEL_3V15 8'h99
`define LVR_VSEL_3V8 8'haa
`define LVR_VSEL_OFF 8'hf0

// Watchdog enable field codes
`define LVR_WDEN_POR 5'h0a
`define LVR_WDEN_ALT 5'h15

// Reset cause bit positions and power-on value
`define LVR_CAUSE_WRF 0
`define LVR_CAUSE_LRF 1
`define LVR_CAUSE_LOW_SUPPLY_RESET_FLAG 2
`define LVR_CAUSE_RESET_CTRL_CORRUPT_FLAG 3
`define LVR_CAUSE_POR 4'h0

// Status bit positions
`define LVR_STAT_TO 0
`define LVR_STAT_PDF 1
`define LVR_STAT_MON 2

// Interrupt event bit positions
`define LVR_EV_LOW 0
`define LVR_EV_VSEL 1
`define LVR_EV_WDEN 2
`define LVR_EV_WDT 3

// Timing
`define LVR_CLK_PERIOD_NS 8
`define LVR_QUAL_TIME_NS 1000
`define LVR_SRESET_TIME_NS 2000
`define LVR_HOLD_CYC 16

`endif

// ===== rtl/lvr_delay.sv
`timescale 1ns/1ns
module lvr_delay #(
  parameter int CYCLES = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  lvr_cnt_if.cnt port_if
);
  localparam int W = $clog2(CYCLES + 1);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic done_reg;
  logic done_next;

  // Restarts whenever run drops, pulses done at terminal count
  always_comb
  begin
    cnt_next = cnt_reg;
    done_next = 1'b0;
    if (!port_if.run)
    begin
      cnt_next = '0;
    end
    else if (cnt_reg == W'(CYCLES - 1))
    begin
      cnt_next = '0;
      done_next = 1'b1;
    end
    else
    begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end
    else if (ce)
    begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign port_if.done = done_reg;
endmodule

// ===== rtl/lvr_pkg.sv
package lvr_pkg;

  typedef enum logic [1:0] {
    LVR_MODE_FAST = 2'b00,
    LVR_MODE_SLOW = 2'b01,
    LVR_MODE_IDLE = 2'b10,
    LVR_MODE_SLEEP = 2'b11
  } lvr_mode_t;

  typedef enum logic [1:0] {
    LVR_ST_RUN = 2'b00,
    LVR_ST_DELAY = 2'b01,
    LVR_ST_HOLD = 2'b10
  } lvr_state_t;

endpackage

// ===== rtl/lvr_top.sv
// How it works
// R1 - Monitor active in fast/slow when code enables
// R2 - Qualified low supply issues device reset
// R3 - Short low supply pulses are ignored
// R4 - Six defined codes: five thresholds, one disable
// R5 - Undefined code: delayed reset, register back
// R6 - Low supply reset keeps select register
// R7 - Power-up loads lowest threshold code
// R8 - Low supply flag sticky, software clears
// R9 - Select corruption flag sticky, software clears
// R10 - Upper four cause bits read zero
// R11 - Active-mode watchdog timeout: full reset, timeout set
// R12 - Sleep timeout clears PC, SP only
// R13 - Timeout/powerdown flags per reset kind
// R14 - Power-on: interrupts off, timer off, SP top
// R15 - Power-on: watchdog cleared and runs, PC zero
// R16 - Bad watchdog enable field: delayed reset, flag
// R17 - Qualify counter restarts when indication drops
`timescale 1ns/1ns
`include "lvr_defines.svh"
module lvr_top #(
  parameter int QUAL_CYC =
    (`LVR_QUAL_TIME_NS + `LVR_CLK_PERIOD_NS - 1) / `LVR_CLK_PERIOD_NS,
  parameter int SRESET_CYC =
    (`LVR_SRESET_TIME_NS + `LVR_CLK_PERIOD_NS - 1) / `LVR_CLK_PERIOD_NS,
  parameter int HOLD_CYC = `LVR_HOLD_CYC
) (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic CE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic LOW_SUPPLY,
  input wire lvr_pkg::lvr_mode_t POWER_MODE,
  input wire logic WDT_TIMEOUT,
  input wire logic WDT_CLR_CMD,
  input wire logic HALT_ENTER,
  input wire logic RST_CTRL_BAD,
  output logic CORE_RST,
  output logic PC_SP_CLR,
  output logic WDT_RUN,
  output logic MONITOR_ACTIVE,
  output logic IRQ
);
  import lvr_pkg::*;

  lvr_cnt_if qual_if ();
  lvr_cnt_if sres_if ();

  lvr_state_t state_reg;
  lvr_state_t state_next;
  logic [4:0] hold_reg;
  logic [4:0] hold_next;
  logic pend_vsel_reg;
  logic pend_vsel_next;
  logic pend_wden_reg;
  logic pend_wden_next;
  logic pend_rstc_reg;
  logic pend_rstc_next;
  logic [7:0] vsel_reg;
  logic [7:0] vsel_next;
  logic [4:0] wden_reg;
  logic [4:0] wden_next;
  logic [3:0] cause_reg;
  logic [3:0] cause_next;
  logic to_reg;
  logic to_next;
  logic pdf_reg;
  logic pdf_next;
  logic [3:0] irq_st_reg;
  logic [3:0] irq_st_next;
  logic [3:0] irq_msk_reg;
  logic [3:0] irq_msk_next;
  logic pcsp_reg;
  logic pcsp_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic low_s1_reg;
  logic low_s2_reg;

  logic vsel_valid;
  logic wden_valid;
  logic mode_active;
  logic mon_en;
  logic wdt_full;
  logic wdt_sleep;
  logic bus_req;
  logic wr_en;
  logic [3:0] ev;

  // Comparator input is asynchronous
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      low_s1_reg <= 1'b0;
      low_s2_reg <= 1'b0;
    end
    else if (CE)
    begin
      low_s1_reg <= LOW_SUPPLY;
      low_s2_reg <= low_s1_reg;
    end
  end

  // R4 code decode
  always_comb
  begin
    vsel_valid = (vsel_reg == `LVR_VSEL_POR) ||
      (vsel_reg == `LVR_VSEL_1V9) || (vsel_reg == `LVR_VSEL_2V55) ||
      (vsel_reg == `LVR_VSEL_3V15) || (vsel_reg == `LVR_VSEL_3V8) ||
      (vsel_reg == `LVR_VSEL_OFF);
    // R16 enable field check
    wden_valid = (wden_reg == `LVR_WDEN_POR) ||
      (wden_reg == `LVR_WDEN_ALT);
    mode_active = (POWER_MODE == LVR_MODE_FAST) ||
      (POWER_MODE == LVR_MODE_SLOW);
    // R1 monitor gating
    mon_en = vsel_valid && (vsel_reg != `LVR_VSEL_OFF) && mode_active;
    // R11 active-mode timeout
    wdt_full = WDT_TIMEOUT && mode_active && (state_reg == LVR_ST_RUN);
    // R12 sleep-mode timeout
    wdt_sleep = WDT_TIMEOUT && !mode_active;
  end

  // R17 qualify counter drive
  assign qual_if.run = low_s2_reg && mon_en && (state_reg == LVR_ST_RUN);
  assign sres_if.run = (state_reg == LVR_ST_DELAY);

  // R2 qualification time
  lvr_delay #(
    .CYCLES(QUAL_CYC)
  ) u_qual (
    .clk(CLK_SYS),
    .rst_n(ARST_N),
    .ce(CE),
    .port_if(qual_if.cnt)
  );

  // R5 soft reset delay
  lvr_delay #(
    .CYCLES(SRESET_CYC)
  ) u_sres (
    .clk(CLK_SYS),
    .rst_n(ARST_N),
    .ce(CE),
    .port_if(sres_if.cnt)
  );

  assign bus_req = WB_CYC_I && WB_STB_I;
  assign wr_en = bus_req && WB_WE_I && WB_SEL_I[0] && !ack_reg;

  // Reset sequencer and register next values
  always_comb
  begin
    state_next = state_reg;
    hold_next = hold_reg;
    pend_vsel_next = pend_vsel_reg;
    pend_wden_next = pend_wden_reg;
    pend_rstc_next = pend_rstc_reg;
    vsel_next = vsel_reg;
    wden_next = wden_reg;
    cause_next = cause_reg;
    to_next = to_reg;
    pdf_next = pdf_reg;
    irq_msk_next = irq_msk_reg;
    irq_st_next = irq_st_reg;
    pcsp_next = wdt_sleep;
    ev = 4'h0;

    // Software writes come first so hardware sets win
    if (wr_en)
    begin
      if (WB_ADR_I == `LVR_ADR_VSEL)
      begin
        vsel_next = WB_DAT_I[7:0];
      end
      else if (WB_ADR_I == `LVR_ADR_CAUSE)
      begin
        // R8 software clears by writing zero
        cause_next = cause_reg & WB_DAT_I[3:0];
      end
      else if (WB_ADR_I == `LVR_ADR_WDEN)
      begin
        wden_next = WB_DAT_I[4:0];
      end
      else if (WB_ADR_I == `LVR_ADR_IRQ_ST)
      begin
        irq_st_next = irq_st_reg & ~WB_DAT_I[3:0];
      end
      else if (WB_ADR_I == `LVR_ADR_IRQ_MSK)
      begin
        irq_msk_next = WB_DAT_I[3:0];
      end
    end

    if (WDT_CLR_CMD)
    begin
      to_next = 1'b0;
      pdf_next = 1'b0;
    end
    if (HALT_ENTER)
    begin
      pdf_next = 1'b1;
    end

    // R13 sleep timeout sets both flags
    if (wdt_sleep)
    begin
      to_next = 1'b1;
      pdf_next = 1'b1;
      ev[`LVR_EV_WDT] = 1'b1;
    end

    case (state_reg)
      LVR_ST_RUN:
      begin
        // R3 only a completed count resets
        if (qual_if.done)
        begin
          state_next = LVR_ST_HOLD;
          hold_next = 5'h0;
          // R8 low supply cause flag
          cause_next[`LVR_CAUSE_LOW_SUPPLY_RESET_FLAG] = 1'b1;
          ev[`LVR_EV_LOW] = 1'b1;
          // R6 select register untouched here
        end
        else if (wdt_full)
        begin
          state_next = LVR_ST_HOLD;
          hold_next = 5'h0;
          // R11 timeout flag on full reset
          to_next = 1'b1;
          ev[`LVR_EV_WDT] = 1'b1;
        end
        else if (!vsel_valid || !wden_valid || RST_CTRL_BAD)
        begin
          state_next = LVR_ST_DELAY;
          pend_vsel_next = !vsel_valid;
          pend_wden_next = !wden_valid;
          pend_rstc_next = RST_CTRL_BAD;
        end
      end
      LVR_ST_DELAY:
      begin
        // R5 reset after the delay
        if (sres_if.done)
        begin
          state_next = LVR_ST_HOLD;
          hold_next = 5'h0;
          if (pend_vsel_reg)
          begin
            // R5 register back to power-on code
            vsel_next = `LVR_VSEL_POR;
            // R9 corruption flag
            cause_next[`LVR_CAUSE_LRF] = 1'b1;
            ev[`LVR_EV_VSEL] = 1'b1;
          end
          if (pend_wden_reg)
          begin
            // R16 watchdog field flag
            cause_next[`LVR_CAUSE_WRF] = 1'b1;
            ev[`LVR_EV_WDEN] = 1'b1;
          end
          if (pend_rstc_reg)
          begin
            cause_next[`LVR_CAUSE_RESET_CTRL_CORRUPT_FLAG] = 1'b1;
          end
          pend_vsel_next = 1'b0;
          pend_wden_next = 1'b0;
          pend_rstc_next = 1'b0;
        end
      end
      LVR_ST_HOLD:
      begin
        // Full reset restores the watchdog field
        wden_next = `LVR_WDEN_POR;
        if (hold_reg == 5'(HOLD_CYC - 1))
        begin
          state_next = LVR_ST_RUN;
        end
        else
        begin
          hold_next = hold_reg + 5'h1;
        end
      end
      default:
      begin
        state_next = LVR_ST_HOLD;
        hold_next = 5'h0;
      end
    endcase

    irq_st_next = irq_st_next | ev;
  end

  // Bus answer
  always_comb
  begin
    ack_next = bus_req && !ack_reg;
    dat_next = 32'h0;
    if (bus_req && !WB_WE_I)
    begin
      if (WB_ADR_I == `LVR_ADR_VSEL)
      begin
        dat_next[7:0] = vsel_reg;
      end
      else if (WB_ADR_I == `LVR_ADR_CAUSE)
      begin
        // R10 upper bits read zero
        dat_next[3:0] = cause_reg;
      end
      else if (WB_ADR_I == `LVR_ADR_STAT)
      begin
        dat_next[`LVR_STAT_TO] = to_reg;
        dat_next[`LVR_STAT_PDF] = pdf_reg;
        dat_next[`LVR_STAT_MON] = mon_en;
      end
      else if (WB_ADR_I == `LVR_ADR_WDEN)
      begin
        dat_next[4:0] = wden_reg;
      end
      else if (WB_ADR_I == `LVR_ADR_IRQ_ST)
      begin
        dat_next[3:0] = irq_st_reg;
      end
      else if (WB_ADR_I == `LVR_ADR_IRQ_MSK)
      begin
        dat_next[3:0] = irq_msk_reg;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      // R14 power-on holds core in reset
      state_reg <= LVR_ST_HOLD;
      hold_reg <= 5'h0;
      pend_vsel_reg <= 1'b0;
      pend_wden_reg <= 1'b0;
      pend_rstc_reg <= 1'b0;
      // R7 lowest threshold at power-up
      vsel_reg <= `LVR_VSEL_POR;
      wden_reg <= `LVR_WDEN_POR;
      cause_reg <= `LVR_CAUSE_POR;
      // R13 power-on clears both flags
      to_reg <= 1'b0;
      pdf_reg <= 1'b0;
      irq_st_reg <= 4'h0;
      irq_msk_reg <= 4'h0;
      pcsp_reg <= 1'b0;
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
    end
    else if (CE)
    begin
      state_reg <= state_next;
      hold_reg <= hold_next;
      pend_vsel_reg <= pend_vsel_next;
      pend_wden_reg <= pend_wden_next;
      pend_rstc_reg <= pend_rstc_next;
      vsel_reg <= vsel_next;
      wden_reg <= wden_next;
      cause_reg <= cause_next;
      to_reg <= to_next;
      pdf_reg <= pdf_next;
      irq_st_reg <= irq_st_next;
      irq_msk_reg <= irq_msk_next;
      pcsp_reg <= pcsp_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  // R14 core reset level
  assign CORE_RST = (state_reg == LVR_ST_HOLD);
  // R15 watchdog runs once reset ends
  assign WDT_RUN = (state_reg != LVR_ST_HOLD);
  // R12 program counter and stack pointer only
  assign PC_SP_CLR = pcsp_reg;
  assign MONITOR_ACTIVE = mon_en;
  assign IRQ = |(irq_st_reg & irq_msk_reg);
  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = dat_reg;
endmodule

// ===== verif/lvr_far_model.sv
`timescale 1ns/1ns
module lvr_far_model (
  input wire logic clk,
  output logic low_supply,
  output logic wdt_timeout,
  output logic wdt_clr,
  output logic halt_enter,
  output logic rst_bad
);
  initial
  begin
    low_supply = 1'b0;
    wdt_timeout = 1'b0;
    wdt_clr = 1'b0;
    halt_enter = 1'b0;
    rst_bad = 1'b0;
  end
  task automatic low_pulse(input int n);
    @(posedge clk);
    low_supply <= 1'b1;
    repeat (n) @(posedge clk);
    low_supply <= 1'b0;
  endtask
  // one-cycle pulse: 0 timeout, 1 clear, 2 halt, 3 bad control
  task automatic strobe(input int k);
    @(posedge clk);
    wdt_timeout <= (k == 0);
    wdt_clr <= (k == 1);
    halt_enter <= (k == 2);
    rst_bad <= (k == 3);
    @(posedge clk);
    wdt_timeout <= 1'b0;
    wdt_clr <= 1'b0;
    halt_enter <= 1'b0;
    rst_bad <= 1'b0;
  endtask
endmodule

// ===== verif/lvr_top_asserts.sv
`timescale 1ns/1ns
module lvr_top_asserts #(
  parameter int QUAL_CYC = 4,
  parameter int HOLD_CYC = 4
) (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic CE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic LOW_SUPPLY,
  input wire lvr_pkg::lvr_mode_t POWER_MODE,
  input wire logic WDT_TIMEOUT,
  input wire logic CORE_RST,
  input wire logic PC_SP_CLR,
  input wire logic WDT_RUN,
  input wire logic MONITOR_ACTIVE
);
  import lvr_pkg::*;
  int low_reg;
  int low_next;
  int hold_reg;
  int hold_next;
  // Cycles of qualifying low supply, and of reset held
  always_comb
  begin
    low_next = (LOW_SUPPLY && MONITOR_ACTIVE) ? low_reg + 1 : 0;
    hold_next = CORE_RST ? hold_reg + 1 : 0;
  end
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      low_reg <= 0;
      hold_reg <= 0;
    end
    else
    begin
      low_reg <= low_next;
      hold_reg <= hold_next;
    end
  end
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!ARST_N);
  chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  chk_ack_answer: assert property
    (CE && WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request not answered");
  chk_wdt_runs: assert property (WDT_RUN == !CORE_RST)
    else $error("watchdog run not inverse of reset");
  chk_monitor_mode: assert property (POWER_MODE[1] |-> !MONITOR_ACTIVE)
    else $error("monitor active in idle or sleep");
  chk_low_qualify: assert property
    (low_reg == QUAL_CYC + 2 |-> ##[0:4] CORE_RST)
    else $error("qualified low supply gave no reset");
  chk_active_wdt: assert property
    (CE && WDT_TIMEOUT && !POWER_MODE[1] && !CORE_RST |=>
      CORE_RST && !PC_SP_CLR)
    else $error("active timeout gave no full reset");
  chk_sleep_wdt: assert property
    (CE && WDT_TIMEOUT && POWER_MODE[1] && !CORE_RST |=>
      PC_SP_CLR && !CORE_RST)
    else $error("sleep timeout wrong reset kind");
  chk_pcsp_cause: assert property
    ($rose(PC_SP_CLR) |-> $past(WDT_TIMEOUT) && $past(POWER_MODE[1]))
    else $error("pc and sp cleared without sleep timeout");
  chk_hold_len: assert property
    ($fell(CORE_RST) |-> hold_reg >= HOLD_CYC - 1)
    else $error("device reset released too early");
endmodule
bind lvr_top lvr_top_asserts #(.QUAL_CYC(QUAL_CYC), .HOLD_CYC(HOLD_CYC))
  asrt_u (.CLK_SYS, .ARST_N, .CE, .WB_CYC_I, .WB_STB_I, .WB_ACK_O,
  .LOW_SUPPLY, .POWER_MODE, .WDT_TIMEOUT, .CORE_RST, .PC_SP_CLR,
  .WDT_RUN, .MONITOR_ACTIVE);

// ===== verif/testbench.sv
`timescale 1ns/1ns
`include "lvr_defines.svh"
module testbench;
  import lvr_pkg::*;
  localparam int QC = 4;
  localparam int SC = 4;
  localparam logic [7:0] CODES [6] = '{8'h66, 8'h55, 8'h33, 8'h99,
    8'haa, 8'hf0};
  logic clk_sys, arst_n, cyc, stb, we, ack, low, wdt, clr, halt, bad, ce;
  logic [3:0] sel;
  logic core_rst, pcsp, wrun, mon, irq;
  logic [7:0] adr;
  logic [31:0] dat_i, dat_o, rd;
  lvr_mode_t mode;
  int err_total, checks;
  logic [7:0] v;
  lvr_top #(.QUAL_CYC(QC), .SRESET_CYC(SC), .HOLD_CYC(4)) dut_u (
    .CLK_SYS(clk_sys), .ARST_N(arst_n), .CE(ce), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .LOW_SUPPLY(low), .POWER_MODE(mode), .WDT_TIMEOUT(wdt),
    .WDT_CLR_CMD(clr), .HALT_ENTER(halt), .RST_CTRL_BAD(bad),
    .CORE_RST(core_rst), .PC_SP_CLR(pcsp), .WDT_RUN(wrun),
    .MONITOR_ACTIVE(mon), .IRQ(irq));
  lvr_far_model far_u (.clk(clk_sys), .low_supply(low), .wdt_timeout(wdt),
    .wdt_clr(clr), .halt_enter(halt), .rst_bad(bad));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= d;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20)
      err_total++;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic rst_seen(input int lim, input logic exp);
    logic hit;
    hit = 1'b0;
    repeat (lim)
    begin
      @(posedge clk_sys);
      hit = hit | (core_rst === 1'b1);
    end
    chk(hit, exp);
    while (core_rst !== 1'b0)
      @(posedge clk_sys);
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    tally_and_finish();
  end
  initial
  begin
    {arst_n, cyc, stb, we, adr, dat_i} = '0;
    ce = 1'b1;
    sel = 4'hf;
    mode = LVR_MODE_FAST;
    void'($urandom(32'h495f));
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    rc(`LVR_ADR_VSEL, 32'h66);
    rc(`LVR_ADR_CAUSE, 32'h0);
    rc(`LVR_ADR_STAT, 32'h4);
    rc(8'h40, 32'h0);
    rst_seen(1, 1'b0);
    $display("power-on test done");
    foreach (CODES[i])
    begin
      mode <= lvr_mode_t'($urandom_range(3));
      wb(1'b1, `LVR_ADR_VSEL, {24'h0, CODES[i]});
      rc(`LVR_ADR_VSEL, {24'h0, CODES[i]});
      @(negedge clk_sys);
      chk(mon, CODES[i] != 8'hf0 && !mode[1]);
      @(posedge clk_sys);
    end
    mode <= LVR_MODE_FAST;
    wb(1'b1, `LVR_ADR_VSEL, 32'h33);
    $display("select code test done");
    far_u.low_pulse(QC - 2);
    rst_seen(12, 1'b0);
    fork
      far_u.low_pulse(QC + 8);
      rst_seen(QC + 12, 1'b1);
    join
    rc(`LVR_ADR_VSEL, 32'h33);
    rc(`LVR_ADR_CAUSE, 32'h4);
    rc(`LVR_ADR_STAT, 32'h4);
    wb(1'b1, `LVR_ADR_CAUSE, 32'h0b);
    rc(`LVR_ADR_CAUSE, 32'h0);
    // Write without the low byte lane is ignored
    sel <= 4'($urandom) & 4'he;
    wb(1'b1, `LVR_ADR_VSEL, 32'h55);
    sel <= 4'hf;
    rc(`LVR_ADR_VSEL, 32'h33);
    $display("low supply test done");
    do
      v = 8'($urandom);
    while (v inside {CODES});
    wb(1'b1, `LVR_ADR_VSEL, {24'h0, v});
    rst_seen(SC + 12, 1'b1);
    rc(`LVR_ADR_VSEL, 32'h66);
    rc(`LVR_ADR_CAUSE, 32'h2);
    wb(1'b1, `LVR_ADR_CAUSE, 32'h0);
    do
      v = 8'($urandom_range(31));
    while (v inside {8'h0a, 8'h15});
    wb(1'b1, `LVR_ADR_WDEN, {24'h0, v});
    rst_seen(SC + 12, 1'b1);
    rc(`LVR_ADR_CAUSE, 32'h1);
    rc(`LVR_ADR_WDEN, 32'h0a);
    wb(1'b1, `LVR_ADR_CAUSE, 32'h0);
    // Bad reset control one-cycle pulse
    far_u.strobe(3);
    rst_seen(SC + 12, 1'b1);
    rc(`LVR_ADR_CAUSE, 32'h8);
    wb(1'b1, `LVR_ADR_CAUSE, 32'h0);
    $display("corruption test done");
    // Clock enable low freezes the block
    ce <= 1'b0;
    fork
      far_u.strobe(0);
      rst_seen(6, 1'b0);
    join
    ce <= 1'b1;
    rc(`LVR_ADR_STAT, 32'h4);
    fork
      far_u.strobe(0);
      rst_seen(6, 1'b1);
    join
    rc(`LVR_ADR_STAT, 32'h5);
    far_u.strobe(1);
    mode <= LVR_MODE_SLEEP;
    fork
      far_u.strobe(0);
      rst_seen(6, 1'b0);
    join
    rc(`LVR_ADR_STAT, 32'h3);
    mode <= LVR_MODE_FAST;
    far_u.strobe(1);
    rc(`LVR_ADR_STAT, 32'h4);
    far_u.strobe(2);
    rc(`LVR_ADR_STAT, 32'h6);
    $display("watchdog test done");
    rc(`LVR_ADR_IRQ_ST, 32'hf);
    chk(irq, 1'b0);
    wb(1'b1, `LVR_ADR_IRQ_MSK, 32'hf);
    @(negedge clk_sys);
    chk(irq, 1'b1);
    wb(1'b1, `LVR_ADR_IRQ_ST, 32'hf);
    @(negedge clk_sys);
    chk(irq, 1'b0);
    rc(`LVR_ADR_IRQ_ST, 32'h0);
    $display("interrupt test done");
    // Second power-on reset in mid-run
    wb(1'b1, `LVR_ADR_VSEL, 32'h99);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    rst_seen(1, 1'b1);
    rc(`LVR_ADR_VSEL, 32'h66);
    rc(`LVR_ADR_STAT, 32'h4);
    rc(`LVR_ADR_CAUSE, 32'h0);
    $display("second reset test done");
    tally_and_finish();
  end
endmodule
